// ### design/saop_pkg.sv
package saop_pkg;
  // register offsets and reset values
  localparam logic [7:0] ADDR_CTRL1 = 8'h01;
  localparam logic [7:0] ADDR_FMT = 8'h05;
  localparam logic [7:0] ADDR_INT1 = 8'h0D;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] FMT_RST = 8'h00;
  // control 1 fields
  localparam int MUTE_BIT = 6;
  localparam int GPO_BIT = 0;
  // interrupt 1 status fields
  localparam int SLIP_BIT = 5;
  // serial output format fields
  localparam int MASTER_BIT = 7;
  localparam int RATE_BIT = 6;
  localparam int RES_HI = 5;
  localparam int RES_LO = 4;
  localparam int JUST_BIT = 3;
  localparam int DLY_BIT = 2;
  localparam int BPOL_BIT = 1;
  localparam int FPOL_BIT = 0;
  localparam logic [1:0] RES_24 = 2'h0;
  localparam logic [1:0] RES_20 = 2'h1;
  localparam logic [1:0] RES_16 = 2'h2;
  localparam logic [1:0] RES_AES = 2'h3;
  localparam logic [6:0] LEN_24 = 7'h18;
  localparam logic [6:0] LEN_20 = 7'h14;
  localparam logic [6:0] LEN_16 = 7'h10;
  localparam logic [6:0] LEN_AES = 7'h1C;
  localparam logic [6:0] HALF_64FS = 7'h20;
  localparam logic [6:0] HALF_128FS = 7'h40;
  // timing
  localparam int CLK_NS = 50;
  localparam int FRAME_NS = 20833;
  localparam int SAME_PCT = 28;
  localparam int SAME_WIN_CYC = FRAME_NS * SAME_PCT / 100 / CLK_NS;
  localparam logic [2:0] CHECK_DLY = 3'h4;
  localparam logic [8:0] HYST_CYC = 9'h008;
  localparam int LAT_FRAMES = 3;
  localparam logic [4:0] BLK_FIRST = 5'h02;
  localparam logic [4:0] BLK_END = 5'h12;
endpackage

// ### design/saop_top.sv
`timescale 1ns/1ps
// Overview of operation
// R1: master drives frame and bit clocks, derived from the device clock.
// R2: slave takes both clocks in; bit clock may be asynchronous and stop.
// R3: external frame clock runs continuously; each phase holds all data bits.
// R4: right justification is honoured only as master.
// R5: output mute bit silences serial audio data at once.
// R6: format register selects master, rate, resolution, justification, delay, polarities.
// R7: software keeps de-emphasis off in AES3-direct format.
// R8: AES3-direct slot carries a block-start bit in place of parity.
// R9: block start indication drives its pin and the general output pin.
// R10: slave checks the past preamble interval a fixed delay after each preamble.
// R11: no buffer update in interval means slip; old frame repeats, flag sets.
// R12: two updates without a frame edge pair means repeat; flag sets.
// R13: one active edge in interval leaves the flag unchanged.
// R14: slip flag sits in status bit 5, stays set until that register is read.
// R15: hysteresis window keeps a jittery frame clock to one event.
// R16: active frame edge is rising, falling when the polarity bit is 1.
// R17: master places the active frame edge at the left preamble start.
// R18: master delivers each sample three frames after reception.
// R19: master preamble-to-edge delay is a few clock periods.
// R20: slave treats samples within 28 percent of the edge as simultaneous.
// R21: slave latency is whole frames plus the frame clock offset.
// R22: several ports may share a bus when the controller gates clocks.
module saop_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic link_bit_clock_in,
  input wire logic frame_clock_in,
  output logic out_frame_clock_out,
  output logic out_frame_clock_oe_out,
  output logic out_bit_clock_out,
  output logic out_bit_clock_oe_out,
  output logic serial_data_out,
  input wire logic sample_valid_in,
  input wire logic [23:0] sample_left_in,
  input wire logic [23:0] sample_right_in,
  input wire logic validity_in,
  input wire logic user_in,
  input wire logic chan_status_in,
  input wire logic block_start_in,
  input wire logic preamble_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic block_start_indicator_out,
  output logic general_output_pin_out
);
  logic [7:0] fmt_r, ctrl1_r, rdata_r;
  logic slip_r, hyst_r, near_r;
  logic fr_s1, fr_s2, fr_s3;
  logic [31:0] pipe_l_r [1:saop_pkg::LAT_FRAMES];
  logic [31:0] pipe_r_r [1:saop_pkg::LAT_FRAMES];
  logic [31:0] xfer_l_r, xfer_r_r;
  logic xfer_tgl_r;
  logic [7:0] win_r;
  logic [1:0] edges_r;
  logic [8:0] since_pre_r;
  logic [2:0] chk_cnt_r;
  logic [4:0] blk_pos_r;
  logic blk_r, gpo_r;
  logic [7:0] mdiv_r;
  logic mfr_r, mbc_r, moe_r;

  wire master = fmt_r[saop_pkg::MASTER_BIT];
  wire fpol = fmt_r[saop_pkg::FPOL_BIT];
  wire [1:0] res = fmt_r[saop_pkg::RES_HI:saop_pkg::RES_LO];
  wire aes_mode = (res == saop_pkg::RES_AES);
  wire [6:0] half_bits = fmt_r[saop_pkg::RATE_BIT] ? saop_pkg::HALF_128FS : saop_pkg::HALF_64FS;
  wire rd_int1 = reg_rd_in && (reg_addr_in == saop_pkg::ADDR_INT1);
  wire wr_fmt = reg_wr_in && (reg_addr_in == saop_pkg::ADDR_FMT);
  wire wr_ctrl1 = reg_wr_in && (reg_addr_in == saop_pkg::ADDR_CTRL1);
  // R16 active edge select
  wire act_edge = fpol ? (fr_s3 && !fr_s2) : (!fr_s3 && fr_s2);
  // R8 parity slot replaced by block start
  wire [7:0] tail = aes_mode ? {validity_in, user_in, chan_status_in, block_start_in, 4'h0}
                             : 8'h00;
  wire [31:0] in_l = {sample_left_in, tail};
  wire [31:0] in_r = {sample_right_in, tail};
  wire eval = (chk_cnt_r == 3'h1);
  wire slip_ev = (edges_r == 2'h0);
  wire rep_ev = (edges_r >= 2'h2);
  // R15 suppress retrigger near preamble
  wire suppress = hyst_r && near_r;
  wire event_w = eval && !master && (slip_ev || rep_ev) && !suppress;
  wire late_sample = sample_valid_in && (win_r != 8'h00);
  wire [7:0] rdata_nxt = (reg_addr_in == saop_pkg::ADDR_FMT) ? fmt_r :
                         (reg_addr_in == saop_pkg::ADDR_CTRL1) ? ctrl1_r :
                         (reg_addr_in == saop_pkg::ADDR_INT1) ? {2'h0, slip_r, 5'h00} : 8'h00;
  wire [4:0] blk_nxt = block_start_in ? 5'h00 : (blk_pos_r == 5'h1F) ? blk_pos_r : blk_pos_r + 5'h01;
  wire [7:0] mdiv_top = {half_bits, 1'b0} + {half_bits, 1'b0} - 8'h01;
  wire act_lvl = !fpol;

  // register port
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fmt_r <= saop_pkg::FMT_RST;
      ctrl1_r <= saop_pkg::CTRL1_RST;
      rdata_r <= 8'h00;
    end else begin
      if (wr_fmt) fmt_r <= reg_wdata_in;
      if (wr_ctrl1) ctrl1_r <= reg_wdata_in;
      if (reg_rd_in) rdata_r <= rdata_nxt;
    end
  end

  // R14 sticky flag, set wins over read clear
  always_ff @(posedge clk_in) begin
    if (reset_in) slip_r <= 1'b0;
    else if (event_w) slip_r <= 1'b1;
    else if (rd_int1) slip_r <= 1'b0;
  end

  // frame pin into device clock domain
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fr_s1 <= 1'b0;
      fr_s2 <= 1'b0;
      fr_s3 <= 1'b0;
    end else begin
      fr_s1 <= frame_clock_in;
      fr_s2 <= fr_s1;
      fr_s3 <= fr_s2;
    end
  end

  // R18 three frame delay line
  genvar g;
  generate
    for (g = 1; g <= saop_pkg::LAT_FRAMES; g++) begin : g_pipe
      wire [31:0] src_l;
      wire [31:0] src_r;
      if (g == 1) begin : g_head
        assign src_l = in_l;
        assign src_r = in_r;
      end else begin : g_body
        assign src_l = pipe_l_r[g-1];
        assign src_r = pipe_r_r[g-1];
      end
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          pipe_l_r[g] <= 32'h0000_0000;
          pipe_r_r[g] <= 32'h0000_0000;
        end else if (sample_valid_in) begin
          pipe_l_r[g] <= src_l;
          pipe_r_r[g] <= src_r;
        end
      end
    end
  endgenerate

  // word handed to the link at each active edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      xfer_l_r <= 32'h0000_0000;
      xfer_r_r <= 32'h0000_0000;
      xfer_tgl_r <= 1'b0;
    end else if (act_edge || late_sample) begin
      // R20 sample close after the edge counts as same instant
      xfer_l_r <= pipe_l_r[saop_pkg::LAT_FRAMES];
      xfer_r_r <= pipe_r_r[saop_pkg::LAT_FRAMES];
      xfer_tgl_r <= !xfer_tgl_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) win_r <= 8'h00;
    else if (act_edge) win_r <= 8'(saop_pkg::SAME_WIN_CYC);
    else if (win_r != 8'h00) win_r <= win_r - 8'h01;
  end

  // R10 fixed delay after preamble, then look back
  always_ff @(posedge clk_in) begin
    if (reset_in) chk_cnt_r <= 3'h0;
    else if (preamble_in) chk_cnt_r <= saop_pkg::CHECK_DLY;
    else if (chk_cnt_r != 3'h0) chk_cnt_r <= chk_cnt_r - 3'h1;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) since_pre_r <= 9'h1FF;
    else if (preamble_in) since_pre_r <= 9'h000;
    else if (since_pre_r != 9'h1FF) since_pre_r <= since_pre_r + 9'h001;
  end

  // R11 R12 R13 edge count over the interval
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      edges_r <= 2'h0;
      near_r <= 1'b0;
    end else if (eval) begin
      edges_r <= {1'b0, act_edge};
      near_r <= act_edge && (since_pre_r < saop_pkg::HYST_CYC);
    end else if (act_edge) begin
      edges_r <= (edges_r == 2'h3) ? edges_r : edges_r + 2'h1;
      near_r <= near_r || (since_pre_r < saop_pkg::HYST_CYC);
    end
  end

  // R15 hysteresis after an event
  always_ff @(posedge clk_in) begin
    if (reset_in) hyst_r <= 1'b0;
    else if (event_w) hyst_r <= 1'b1;
    else if (eval && edges_r == 2'h1 && !near_r) hyst_r <= 1'b0;
  end

  // R9 block start indication
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      blk_pos_r <= 5'h1F;
      blk_r <= 1'b0;
      gpo_r <= 1'b0;
    end else begin
      if (sample_valid_in) blk_pos_r <= blk_nxt;
      blk_r <= (blk_pos_r >= saop_pkg::BLK_FIRST) && (blk_pos_r < saop_pkg::BLK_END);
      gpo_r <= ctrl1_r[saop_pkg::GPO_BIT] &&
               (blk_pos_r >= saop_pkg::BLK_FIRST) && (blk_pos_r < saop_pkg::BLK_END);
    end
  end

  // R1 R17 R19 master clock generation, restarted at left preamble
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mdiv_r <= 8'h00;
      mfr_r <= 1'b0;
      mbc_r <= 1'b0;
      moe_r <= 1'b0;
    end else begin
      moe_r <= master;
      if (preamble_in || mdiv_r == mdiv_top) mdiv_r <= 8'h00;
      else mdiv_r <= mdiv_r + 8'h01;
      mfr_r <= (preamble_in || mdiv_r == mdiv_top) ? act_lvl :
               (mdiv_r == {half_bits, 1'b0} - 8'h01) ? !act_lvl : mfr_r;
      mbc_r <= (preamble_in || mdiv_r == mdiv_top) ? fmt_r[saop_pkg::BPOL_BIT]
                                                   : !mbc_r;
    end
  end

  assign out_frame_clock_out = mfr_r;
  assign out_bit_clock_out = mbc_r;
  assign out_frame_clock_oe_out = moe_r;
  assign out_bit_clock_oe_out = moe_r;
  assign reg_rdata_out = rdata_r;
  assign block_start_indicator_out = blk_r;
  assign general_output_pin_out = gpo_r;

  // link domain, clocked by the bit clock pin
  logic rl1, rl2;
  logic [7:0] fs1, fs2;
  logic mu1, mu2;
  logic tg1, tg2, tg3;
  logic lf1, lf2, lf3;
  logic [31:0] stage_l_r, stage_r_r, cur_r;
  logic [6:0] bitcnt_r;
  logic sdo_r;

  wire [1:0] lres = fs2[saop_pkg::RES_HI:saop_pkg::RES_LO];
  wire [6:0] llen = (lres == saop_pkg::RES_24) ? saop_pkg::LEN_24 :
                    (lres == saop_pkg::RES_20) ? saop_pkg::LEN_20 :
                    (lres == saop_pkg::RES_16) ? saop_pkg::LEN_16 : saop_pkg::LEN_AES;
  wire [6:0] lhalf = fs2[saop_pkg::RATE_BIT] ? saop_pkg::HALF_128FS : saop_pkg::HALF_64FS;
  // R4 right justification only as master
  wire ljust = fs2[saop_pkg::JUST_BIT] && fs2[saop_pkg::MASTER_BIT];
  wire [6:0] lstart = ljust ? lhalf - llen : {6'h00, fs2[saop_pkg::DLY_BIT]};
  wire [6:0] lpos = bitcnt_r - lstart;
  wire lin = (bitcnt_r >= lstart) && (lpos < llen);
  wire lbit = lin ? cur_r[5'(7'h1F - lpos)] : 1'b0;
  wire ledge = (lf2 != lf3);
  wire lleft = (lf2 == !fs2[saop_pkg::FPOL_BIT]);

  // R2 reset and settings brought over to the bit clock
  always_ff @(posedge link_bit_clock_in) begin
    rl1 <= reset_in;
    rl2 <= rl1;
  end

  always_ff @(posedge link_bit_clock_in) begin
    if (rl2) begin
      fs1 <= 8'h00;
      fs2 <= 8'h00;
      mu1 <= 1'b0;
      mu2 <= 1'b0;
      tg1 <= 1'b0;
      tg2 <= 1'b0;
      tg3 <= 1'b0;
      lf1 <= 1'b0;
      lf2 <= 1'b0;
      lf3 <= 1'b0;
    end else begin
      fs1 <= fmt_r;
      fs2 <= fs1;
      mu1 <= ctrl1_r[saop_pkg::MUTE_BIT];
      mu2 <= mu1;
      tg1 <= xfer_tgl_r;
      tg2 <= tg1;
      tg3 <= tg2;
      lf1 <= frame_clock_in;
      lf2 <= lf1;
      lf3 <= lf2;
    end
  end

  // R21 word taken on toggle, shifted from the next frame edge
  always_ff @(posedge link_bit_clock_in) begin
    if (rl2) begin
      stage_l_r <= 32'h0000_0000;
      stage_r_r <= 32'h0000_0000;
    end else if (tg2 != tg3) begin
      stage_l_r <= xfer_l_r;
      stage_r_r <= xfer_r_r;
    end
  end

  // R6 slot position counter
  always_ff @(posedge link_bit_clock_in) begin
    if (rl2) begin
      bitcnt_r <= 7'h7F;
      cur_r <= 32'h0000_0000;
    end else if (ledge) begin
      bitcnt_r <= 7'h00;
      cur_r <= lleft ? stage_l_r : stage_r_r;
    end else if (bitcnt_r != 7'h7F) begin
      bitcnt_r <= bitcnt_r + 7'h01;
    end
  end

  // R5 mute forces data low
  always_ff @(posedge link_bit_clock_in) begin
    if (rl2) sdo_r <= 1'b0;
    else sdo_r <= lbit && !mu2;
  end

  assign serial_data_out = sdo_r;

  // checks, device clock domain except the mute check on the bit clock
  sequence s_check_due;
    !preamble_in [*3] ##1 !preamble_in;
  endsequence

  // R10
  chk_check_delay: assert property (@(posedge clk_in) disable iff (reset_in)
    preamble_in ##1 s_check_due |-> eval)
    else $error("look-back check not at fixed delay");
  // R11
  chk_slip_sets: assert property (@(posedge clk_in) disable iff (reset_in)
    eval && !master && edges_r == 2'h0 && !suppress |=> slip_r)
    else $error("slip did not set flag");
  // R12
  chk_repeat_sets: assert property (@(posedge clk_in) disable iff (reset_in)
    eval && !master && edges_r >= 2'h2 && !suppress |=> slip_r)
    else $error("repeat did not set flag");
  // R13
  chk_one_edge_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    eval && edges_r == 2'h1 && !rd_int1 |=> slip_r == $past(slip_r))
    else $error("flag changed without event");
  // R14
  chk_flag_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
    slip_r && !rd_int1 |=> slip_r)
    else $error("flag dropped without read");
  // R14
  chk_read_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_int1 && !event_w ##1 !event_w |-> !slip_r)
    else $error("read did not clear flag");
  // R1
  chk_master_drives: assert property (@(posedge clk_in) disable iff (reset_in)
    master ##1 master |-> out_frame_clock_oe_out && out_bit_clock_oe_out)
    else $error("master not driving clocks");
  // R17
  chk_master_align: assert property (@(posedge clk_in) disable iff (reset_in)
    master && $stable(fmt_r) && preamble_in |=> out_frame_clock_out == !fpol)
    else $error("frame edge not at preamble");
  // R9
  chk_gpo_follow: assert property (@(posedge clk_in) disable iff (reset_in)
    ctrl1_r[saop_pkg::GPO_BIT] ##1 ctrl1_r[saop_pkg::GPO_BIT]
      |-> general_output_pin_out == block_start_indicator_out)
    else $error("general output not following block start");
  // R5
  chk_mute_data: assert property (@(posedge link_bit_clock_in) disable iff (rl2)
    mu2 |=> !serial_data_out)
    else $error("muted output carries data");
endmodule // saop_top

// ### verif/saop_dsp_model.sv
`timescale 1ns/1ps
module saop_dsp_model (
  input wire logic data_in,
  output logic bit_clock_out,
  output logic frame_clock_out,
  output logic [5:0] ones_cnt_out,
  output logic [5:0] first_idx_out
);
  logic [5:0] idx_r, cnt_r, first_r;
  initial begin
    bit_clock_out = 1'b0;
    frame_clock_out = 1'b0;
    idx_r = 6'h00;
    cnt_r = 6'h00;
    first_r = 6'h3F;
    ones_cnt_out = 6'h00;
    first_idx_out = 6'h3F;
    #17;
    forever #32 bit_clock_out = ~bit_clock_out;
  end
  // one slot per phase, 32 bit clocks each
  always @(negedge bit_clock_out) begin
    if (data_in === 1'b1) begin
      cnt_r = cnt_r + 6'h01;
      if (first_r == 6'h3F) begin
        first_r = idx_r;
      end
    end
    idx_r = idx_r + 6'h01;
    if (idx_r == 6'h20) begin
      ones_cnt_out <= cnt_r;
      first_idx_out <= first_r;
      cnt_r = 6'h00;
      first_r = 6'h3F;
      idx_r = 6'h00;
      frame_clock_out <= ~frame_clock_out;
    end
  end
endmodule // saop_dsp_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_in, reset_in, bclk_wire, fclk_wire, dsp_bclk, dsp_fclk, fclk_drv, fclk_oe;
  logic bclk_drv, bclk_oe, sdata, feed_v, feed_en, man_v, man_pre, vuc, bs, wr, rd;
  logic blk_ind, general_output_pin, prev;
  logic [7:0] addr, wdata, rdata, v, tcnt;
  logic [5:0] ones, first;
  logic [6:0] feed_cnt;
  int error_cnt, checks_done;
  assign bclk_wire = bclk_oe ? bclk_drv : dsp_bclk;
  assign fclk_wire = fclk_oe ? fclk_drv : dsp_fclk;
  saop_top dut (.clk_in(clk_in), .reset_in(reset_in), .link_bit_clock_in(bclk_wire),
    .frame_clock_in(fclk_wire), .out_frame_clock_out(fclk_drv),
    .out_frame_clock_oe_out(fclk_oe), .out_bit_clock_out(bclk_drv),
    .out_bit_clock_oe_out(bclk_oe), .serial_data_out(sdata),
    .sample_valid_in(feed_v | man_v), .sample_left_in(24'hFFFFFF),
    .sample_right_in(24'hFFFFFF), .validity_in(vuc), .user_in(vuc), .chan_status_in(vuc),
    .block_start_in(bs), .preamble_in(feed_v | man_pre), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .block_start_indicator_out(blk_ind), .general_output_pin_out(general_output_pin));
  saop_dsp_model dsp (.data_in(sdata), .bit_clock_out(dsp_bclk), .frame_clock_out(dsp_fclk),
    .ones_cnt_out(ones), .first_idx_out(first));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    if (feed_en && feed_cnt == 7'h51) begin
      feed_v <= 1'b1;
      feed_cnt <= 7'h00;
    end else begin
      feed_v <= 1'b0;
      feed_cnt <= feed_cnt + {6'h00, feed_en};
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask
  task automatic meas(input logic [7:0] fmt, input logic [7:0] n, input logic [7:0] f);
    wreg(saop_pkg::ADDR_FMT, fmt);
    repeat (700) @(negedge clk_in);
    cmp8({2'h0, ones}, n);
    cmp8({2'h0, first}, f);
  endtask
  task automatic pre(input int gap);
    @(negedge clk_in);
    man_pre = 1'b1;
    @(negedge clk_in);
    man_pre = 1'b0;
    repeat (gap) @(negedge clk_in);
  endtask
  task automatic edge_pre(input int n);
    repeat (n) @(posedge fclk_wire);
    repeat (20) @(negedge clk_in);
    pre(10);
  endtask
  task automatic align(input logic [7:0] fmt, input logic [7:0] exp);
    wreg(saop_pkg::ADDR_FMT, fmt);
    repeat (100) @(negedge clk_in);
    repeat (400) begin
      prev = fclk_wire;
      @(negedge clk_in);
      if (feed_v === 1'b1) cmp8({6'h00, prev, fclk_wire}, exp);
    end
  endtask
  task automatic smp(input logic b);
    @(negedge clk_in);
    man_v = 1'b1;
    bs = b;
    @(negedge clk_in);
    man_v = 1'b0;
    bs = 1'b0;
    repeat (20) @(negedge clk_in);
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    test_done;
  end
  initial begin
    {feed_en, man_v, man_pre, vuc, bs, wr, rd} = 7'h00;
    {addr, wdata, feed_cnt} = 23'h000000;
    error_cnt = 0;
    checks_done = 0;
    reset_in = 1'b1;
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    rreg(saop_pkg::ADDR_FMT, v);
    cmp8(v, saop_pkg::FMT_RST);
    rreg(saop_pkg::ADDR_INT1, v);
    cmp8(v, 8'h00);
    wreg(saop_pkg::ADDR_INT1, 8'hFF);
    rreg(saop_pkg::ADDR_INT1, v);
    cmp8(v, 8'h00);
    wreg(8'h33, 8'hFF);
    rreg(8'h33, v);
    cmp8(v, 8'h00);
    wreg(saop_pkg::ADDR_FMT, 8'h7F);
    rreg(saop_pkg::ADDR_FMT, v);
    cmp8(v, 8'h7F);
    feed_en = 1'b1;
    meas(8'h00, 8'h18, 8'h03);
    meas(8'h10, 8'h14, 8'h03);
    meas(8'h20, 8'h10, 8'h03);
    meas(8'h04, 8'h18, 8'h04);
    meas(8'h08, 8'h18, 8'h03);
    vuc = 1'b1;
    meas(8'h30, 8'h1B, 8'h03);
    vuc = 1'b0;
    wreg(saop_pkg::ADDR_CTRL1, 8'h40);
    meas(8'h00, 8'h00, 8'h3F);
    wreg(saop_pkg::ADDR_CTRL1, 8'h00);
    feed_en = 1'b0;
    edge_pre(1);
    pre(10);
    rreg(saop_pkg::ADDR_INT1, v);
    cmp8(v, 8'h20);
    rreg(saop_pkg::ADDR_INT1, v);
    cmp8(v, 8'h00);
    edge_pre(1);
    edge_pre(1);
    rreg(saop_pkg::ADDR_INT1, v);
    cmp8(v, 8'h00);
    edge_pre(2);
    rreg(saop_pkg::ADDR_INT1, v);
    cmp8(v, 8'h20);
    wreg(saop_pkg::ADDR_CTRL1, 8'h01);
    smp(1'b1);
    repeat (4) smp(1'b0);
    cmp8({6'h00, blk_ind, general_output_pin}, 8'h03);
    wreg(saop_pkg::ADDR_CTRL1, 8'h00);
    repeat (2) @(negedge clk_in);
    cmp8({6'h00, blk_ind, general_output_pin}, 8'h02);
    repeat (16) smp(1'b0);
    cmp8({6'h00, blk_ind, general_output_pin}, 8'h00);
    wreg(saop_pkg::ADDR_FMT, 8'h80);
    repeat (4) @(negedge clk_in);
    cmp8({6'h00, fclk_oe, bclk_oe}, 8'h03);
    tcnt = 8'h00;
    prev = fclk_wire;
    repeat (600) begin
      @(negedge clk_in);
      if (fclk_wire !== prev) begin
        tcnt = tcnt + 8'h01;
      end
      prev = fclk_wire;
    end
    cmp8({7'h00, tcnt != 8'h00}, 8'h01);
    feed_en = 1'b1;
    align(8'h80, 8'h01);
    align(8'h81, 8'h02);
    feed_en = 1'b0;
    wreg(saop_pkg::ADDR_FMT, 8'h00);
    repeat (4) @(negedge clk_in);
    cmp8({6'h00, fclk_oe, bclk_oe}, 8'h00);
    test_done;
  end
endmodule // tb_top
